// ==== tb/cpu_operand_addressing_bench.sv ====
// self-checking bench for the operand addressing core
`include "oad_consts.svh"
module cpu_operand_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock;
  logic        i_arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] o_pc;
  wire  [7:0]  o_loc_addr;
  wire         o_loc_regsp;
  wire         o_loc_wr;
  wire  [7:0]  o_loc_wdata;
  wire  [1:0]  o_instr_len;
  logic [7:0]  ra, rx, rsp, rf;
  logic [15:0] pc;
  logic [31:0] rd;
  logic        er;
  int          err_count, cmp_count, wr_cnt;
  oad_core u_oad_core (.i_clock(i_clock), .i_arst_n(i_arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .o_pc(o_pc), .o_loc_addr(o_loc_addr),
    .o_loc_regsp(o_loc_regsp), .o_loc_wr(o_loc_wr), .o_loc_wdata(o_loc_wdata),
    .o_instr_len(o_instr_len));
  // ----------------------------------------
  // clock, store pulse counter, watchdog
  // ----------------------------------------
  initial i_clock = 1'b0;
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_loc_wr === 1'b1) wr_cnt++;
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] pick(input logic [1:0] k);
    case (k)
      2'h0: pick = ra;
      2'h1: pick = rx;
      2'h2: pick = rsp;
      default: pick = rf;
    endcase
  endfunction
  task automatic exec(input logic [7:0] ins, input logic [15:0] opnd, input logic [7:0] src);
    logic [2:0] m;
    logic [7:0] s, s2, r, ad;
    logic [1:0] ln;
    int w0;
    m = ins[2:0];
    ln = (m == 3'h5) ? 2'h3 : 2'h2;
    ad = (m == 3'h2 || m == 3'h4) ? opnd[7:0] + rx : opnd[7:0];
    case (m)
      3'h0: begin s = opnd[7:0]; s2 = pick(ins[5:4]); end
      3'h1, 3'h2: begin s = src; s2 = pick({1'b0, ins[4]}); end
      3'h3: begin s = pick({1'b0, ins[4]}); s2 = src; end
      3'h4: begin s = ra; s2 = src; end
      default: begin s = opnd[15:8]; s2 = src; end
    endcase
    r = ins[7] ? s + s2 : s;
    if (m == 3'h0) begin
      case (ins[5:4])
        2'h0: ra = r;
        2'h1: rx = r;
        2'h2: rsp = r;
        default: rf = r;
      endcase
    end else if (m < 3'h3) begin
      if (ins[4]) rx = r;
      else ra = r;
    end
    pc = pc + 16'(ln);
    xfer(1'b1, `OAD_OFF_INSTR, {24'h0, ins});
    xfer(1'b1, `OAD_OFF_OPND, {16'h0, opnd});
    xfer(1'b1, `OAD_OFF_SRC, {24'h0, src});
    w0 = wr_cnt;
    xfer(1'b1, `OAD_OFF_CTRL, 32'h1);
    repeat (3) @(posedge i_clock);
    chk(32'(wr_cnt - w0), {31'h0, m >= 3'h3});
    chk({16'h0, o_pc}, {16'h0, pc});
    chk({30'h0, o_instr_len}, {30'h0, ln});
    xfer(1'b0, `OAD_OFF_REGS, 32'h0);
    chk(rd, {rf, rsp, rx, ra});
    xfer(1'b0, `OAD_OFF_RESULT, 32'h0);
    chk(rd & ((m == 3'h0) ? 32'hff03_0000 : 32'hff03_80ff),
        {r, 6'h0, ln, ins[6], 7'h0, ad} & ((m == 3'h0) ? 32'hff03_0000 : 32'hff03_80ff));
    xfer(1'b0, `OAD_OFF_PCL, 32'h0);
    chk(rd[7:0], pc[7:0]);
    if (m >= 3'h3) begin
      chk({15'h0, o_loc_regsp, o_loc_addr, o_loc_wdata}, {15'h0, ins[6], ad, r});
      xfer(1'b0, `OAD_OFF_LOC, 32'h0);
      chk(rd[7:0], r);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    wr_cnt = 0;
    ra = 8'h00;
    rx = 8'h00;
    rsp = 8'h00;
    rf = `OAD_F_RST;
    pc = 16'h0000;
    repeat (12) @(posedge i_clock);
    i_arst_n <= 1'b1;
    chk({16'h0, o_pc}, 32'h0);
    chk({30'h0, o_instr_len}, {30'h0, `OAD_LEN_TWO});
    xfer(1'b0, `OAD_OFF_PCH, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, `OAD_OFF_REGS, 32'h0);
    chk(rd, {rf, 24'h0});
    // read-only and unmapped places refuse
    xfer(1'b1, `OAD_OFF_PCL, 32'h5a);
    chk({31'h0, er}, 32'h1);
    xfer(1'b0, `OAD_OFF_PCL, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, `OAD_OFF_REGS, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    xfer(1'b0, 32'h0000_0024, 32'h0);
    chk({31'h0, er}, 32'h1);
    exec(8'h00, 16'h0030, 8'h00);
    exec(8'h10, 16'h00f0, 8'h00);
    exec(8'ha0, 16'h0005, 8'h00);
    exec(8'hb0, 16'h0011, 8'h00);
    exec(8'hc1, 16'h0040, 8'h22);
    exec(8'h12, 16'h0020, 8'h07);
    exec(8'h93, 16'h0033, 8'h01);
    exec(8'h43, 16'h0008, 8'h00);
    exec(8'h84, 16'h00ff, 8'hb0);
    exec(8'h45, 16'h0608, 8'h00);
    exec(8'h85, 16'h0507, 8'h10);
    exec(8'hd2, 16'h0001, 8'h03);
    report_and_stop();
  end
endmodule

// ==== verilog/oad_addr_gen.sv ====
// operand address former: direct or index plus operand, 8-bit wrap
module oad_addr_gen
  import oad_pkg::*;
(
  input  wire oad_mode_t  i_mode,
  input  wire logic [7:0] i_opnd1,
  input  wire logic [7:0] i_index,
  output logic [7:0]      o_addr
);
  logic [8:0] sum;
  always_comb begin
    sum = {1'b0, i_opnd1} + {1'b0, i_index};
    if (i_mode == OAD_SRC_IDX || i_mode == OAD_DST_IDX) begin
      o_addr = sum[7:0];
    end else begin
      o_addr = i_opnd1;
    end
  end
endmodule

// ==== verilog/oad_byte_reg.sv ====
// 8-bit register with load enable and constant reset value
module oad_byte_reg #(
  parameter logic [7:0] RST = 8'h00
) (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_load,
  input  wire logic [7:0] i_d,
  output logic [7:0]      o_q
);
  logic [7:0] q_next;
  always_comb begin
    q_next = i_load ? i_d : o_q;
  end
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_q <= RST;
    end else begin
      o_q <= q_next;
    end
  end
endmodule

// ==== verilog/oad_consts.svh ====
// constants for the operand addressing block
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH
`define OAD_OFF_PCL        32'h0000_0000
`define OAD_OFF_PCH        32'h0000_0004
`define OAD_OFF_INSTR      32'h0000_0008
`define OAD_OFF_OPND       32'h0000_000c
`define OAD_OFF_REGS       32'h0000_0010
`define OAD_OFF_SRC        32'h0000_0014
`define OAD_OFF_RESULT     32'h0000_0018
`define OAD_OFF_LOC        32'h0000_001c
`define OAD_OFF_CTRL       32'h0000_0020
`define OAD_INSTR_MODE_LSB 0
`define OAD_INSTR_SEL_LSB  4
`define OAD_INSTR_REGSP    6
`define OAD_INSTR_ARITH    7
`define OAD_PC_RST         8'h00
`define OAD_F_RST          8'h02
`define OAD_LEN_TWO        2'h2
`define OAD_LEN_THREE      2'h3
`define OAD_CTRL_GO        0
`define OAD_CTRL_STEP      1
`endif

// ==== verilog/oad_core.sv ====
// operand addressing core: decode, location access and apb registers
//
// Implementation choices: the address map and the APB interface to the registers.
`include "oad_consts.svh"

module oad_core
  import oad_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_loc_addr,
  output logic             o_loc_regsp,
  output logic             o_loc_wr,
  output logic [7:0]       o_loc_wdata,
  output logic [1:0]       o_instr_len
);
  // ----------------------------------------------------------------
  // decode and architectural state
  // ----------------------------------------------------------------
  logic [7:0]  instr_reg, instr_next;
  logic [7:0]  opnd1_reg, opnd1_next, opnd2_reg, opnd2_next;
  logic [7:0]  loc_rd_reg, loc_rd_next;
  logic [7:0]  res_reg, res_next;
  logic [7:0]  a_q, x_q, stack_pointer_q, f_q, pcl_q, pch_q;
  logic [7:0]  a_d, x_d, stack_pointer_d, f_d, pcl_d, pch_d;
  logic        a_ld, x_ld, stack_pointer_ld, f_ld, pc_ld;
  logic        go_reg, go_next;
  logic        wr_reg, wr_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic        regsp_reg, regsp_next;
  logic [7:0]  wdat_reg, wdat_next;
  logic [1:0]  len_reg, len_next;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;
  oad_mode_t   mode;
  oad_reg_t    rsel;
  logic        arith;
  logic [7:0]  eff_addr, src, second, result;
  logic        acc;

  oad_byte_reg #(.RST(8'h00)) u_a (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(a_ld), .i_d(a_d), .o_q(a_q));
  oad_byte_reg #(.RST(8'h00)) u_x (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(x_ld), .i_d(x_d), .o_q(x_q));
  oad_byte_reg #(.RST(8'h00)) u_stack_pointer (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(stack_pointer_ld), .i_d(stack_pointer_d), .o_q(stack_pointer_q));
  oad_byte_reg #(.RST(`OAD_F_RST)) u_f (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(f_ld), .i_d(f_d), .o_q(f_q));
  oad_byte_reg #(.RST(`OAD_PC_RST)) u_pcl (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(pc_ld), .i_d(pcl_d), .o_q(pcl_q));
  oad_byte_reg #(.RST(`OAD_PC_RST)) u_pch (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_load(pc_ld), .i_d(pch_d), .o_q(pch_q));

  always_comb begin
    mode  = oad_mode_t'(instr_reg[`OAD_INSTR_MODE_LSB +: 3]);
    rsel  = oad_reg_t'(instr_reg[`OAD_INSTR_SEL_LSB +: 2]);
    arith = instr_reg[`OAD_INSTR_ARITH];
  end

  oad_addr_gen u_agen (.i_mode(mode), .i_opnd1(opnd1_reg), .i_index(x_q), .o_addr(eff_addr));

  // ----------------------------------------------------------------
  // operand select and execute
  // ----------------------------------------------------------------
  always_comb begin
    acc    = 1'b0;
    src    = opnd1_reg;
    second = 8'h00;
    case (rsel)
      OAD_R_A:  second = a_q;
      OAD_R_X:  second = x_q;
      OAD_R_STACK_POINTER: second = stack_pointer_q;
      OAD_R_F:  second = f_q;
      default:  second = a_q;
    endcase
    case (mode)
      OAD_SRC_IMM: src = opnd1_reg;
      OAD_SRC_DIR, OAD_SRC_IDX: begin
        src = loc_rd_reg;
        second = rsel[0] ? x_q : a_q;
      end
      OAD_DST_DIR: begin
        src = rsel[0] ? x_q : a_q;
        second = loc_rd_reg;
      end
      OAD_DST_IDX: begin
        src = a_q;
        second = loc_rd_reg;
      end
      OAD_DST_DIR_IMM: begin
        src = opnd2_reg;
        second = loc_rd_reg;
      end
      default: src = opnd1_reg;
    endcase
    result = arith ? src + second : src;
    acc = (mode == OAD_SRC_IMM || mode == OAD_SRC_DIR || mode == OAD_SRC_IDX);
  end

  always_comb begin
    a_ld = 1'b0;
    x_ld = 1'b0;
    stack_pointer_ld = 1'b0;
    f_ld = 1'b0;
    a_d = result;
    x_d = result;
    stack_pointer_d = result;
    f_d = result;
    len_next = (mode == OAD_DST_DIR_IMM) ? `OAD_LEN_THREE : `OAD_LEN_TWO;
    pc_ld = go_reg;
    {pch_d, pcl_d} = {pch_q, pcl_q} + {14'h0000, len_next};
    wr_next = 1'b0;
    waddr_next = waddr_reg;
    regsp_next = regsp_reg;
    wdat_next = wdat_reg;
    res_next = res_reg;
    if (go_reg) begin
      res_next = result;
      // location outputs frozen at the step, not tracking later index changes
      waddr_next = eff_addr;
      regsp_next = instr_reg[`OAD_INSTR_REGSP];
      wdat_next = result;
      if (acc) begin
        if (mode == OAD_SRC_IMM) begin
          a_ld = (rsel == OAD_R_A);
          x_ld = (rsel == OAD_R_X);
          stack_pointer_ld = (rsel == OAD_R_STACK_POINTER);
          f_ld = (rsel == OAD_R_F);
        end else begin
          a_ld = !rsel[0];
          x_ld = rsel[0];
        end
      end else begin
        wr_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic setup;
  always_comb begin
    setup = psel && !penable;
    instr_next = instr_reg;
    opnd1_next = opnd1_reg;
    opnd2_next = opnd2_reg;
    loc_rd_next = loc_rd_reg;
    go_next = 1'b0;
    prdata_next = prdata;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      case (paddr)
        `OAD_OFF_PCL:    prdata_next = {24'h000000, pcl_q};
        `OAD_OFF_PCH:    prdata_next = {24'h000000, pch_q};
        `OAD_OFF_INSTR:  prdata_next = {24'h000000, instr_reg};
        `OAD_OFF_OPND:   prdata_next = {16'h0000, opnd2_reg, opnd1_reg};
        `OAD_OFF_REGS:   prdata_next = {f_q, stack_pointer_q, x_q, a_q};
        `OAD_OFF_SRC:    prdata_next = {24'h000000, loc_rd_reg};
        `OAD_OFF_RESULT: prdata_next = {res_reg, 6'h00, len_reg, regsp_reg, 7'h00, waddr_reg};
        `OAD_OFF_LOC:    prdata_next = {24'h000000, wdat_reg};
        `OAD_OFF_CTRL:   prdata_next = 32'h0000_0000;
        default:         pslverr_next = 1'b1;
      endcase
      if (pwrite) begin
        case (paddr)
          `OAD_OFF_INSTR: instr_next = pwdata[7:0];
          `OAD_OFF_OPND: begin
            opnd1_next = pwdata[7:0];
            opnd2_next = pwdata[15:8];
          end
          `OAD_OFF_SRC:  loc_rd_next = pwdata[7:0];
          `OAD_OFF_CTRL: go_next = pwdata[`OAD_CTRL_GO];
          `OAD_OFF_PCL, `OAD_OFF_PCH, `OAD_OFF_REGS, `OAD_OFF_RESULT,
          `OAD_OFF_LOC: pslverr_next = 1'b1;
          default: pslverr_next = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      instr_reg <= 8'h00;
      opnd1_reg <= 8'h00;
      opnd2_reg <= 8'h00;
      loc_rd_reg <= 8'h00;
      res_reg <= 8'h00;
      go_reg <= 1'b0;
      wr_reg <= 1'b0;
      waddr_reg <= 8'h00;
      regsp_reg <= 1'b0;
      wdat_reg <= 8'h00;
      len_reg <= `OAD_LEN_TWO;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      instr_reg <= instr_next;
      opnd1_reg <= opnd1_next;
      opnd2_reg <= opnd2_next;
      loc_rd_reg <= loc_rd_next;
      res_reg <= res_next;
      go_reg <= go_next;
      wr_reg <= wr_next;
      waddr_reg <= waddr_next;
      regsp_reg <= regsp_next;
      wdat_reg <= wdat_next;
      len_reg <= len_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  assign o_pc = {pch_q, pcl_q};
  assign o_loc_addr = waddr_reg;
  assign o_loc_regsp = regsp_reg;
  assign o_loc_wr = wr_reg;
  assign o_loc_wdata = wdat_reg;
  assign o_instr_len = len_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pc_step;
    @(posedge i_clock) disable iff (!i_arst_n)
      go_reg |=> (o_pc == $past(o_pc) + {14'h0000, $past(len_next)});
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not advanced by length");

  property p_len3;
    @(posedge i_clock) disable iff (!i_arst_n)
      (mode == OAD_DST_DIR_IMM) |=> (o_instr_len == 2'h3);
  endproperty
  a_len3: assert property (p_len3) else $error("three byte length wrong");

  property p_len2;
    @(posedge i_clock) disable iff (!i_arst_n)
      (mode != OAD_DST_DIR_IMM) |=> (o_instr_len == 2'h2);
  endproperty
  a_len2: assert property (p_len2) else $error("two byte length wrong");

  property p_acc_keep;
    @(posedge i_clock) disable iff (!i_arst_n)
      (go_reg && !acc) |=> (a_q == $past(a_q)) && o_loc_wr;
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("accumulator changed");

  property p_idx_addr;
    @(posedge i_clock) disable iff (!i_arst_n)
      (go_reg && mode == OAD_DST_IDX) |=> (o_loc_addr == $past(opnd1_reg + x_q));
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

  property p_dir_addr;
    @(posedge i_clock) disable iff (!i_arst_n)
      (go_reg && mode == OAD_DST_DIR) |=> (o_loc_addr == $past(opnd1_reg));
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");

  property p_regsp;
    @(posedge i_clock) disable iff (!i_arst_n)
      go_reg |=> (o_loc_regsp == $past(instr_reg[6]));
  endproperty
  a_regsp: assert property (p_regsp) else $error("space select wrong");

  property p_imm_dst;
    @(posedge i_clock) disable iff (!i_arst_n)
      (go_reg && mode == OAD_DST_DIR_IMM && !arith) |=> (o_loc_wdata == $past(opnd2_reg));
  endproperty
  a_imm_dst: assert property (p_imm_dst) else $error("literal store wrong");

  property p_pc_ro;
    @(posedge i_clock) disable iff (!i_arst_n)
      !go_reg |=> (o_pc == $past(o_pc));
  endproperty
  a_pc_ro: assert property (p_pc_ro) else $error("pc moved without step");
endmodule

// ==== verilog/oad_pkg.sv ====
// types for the operand addressing block
package oad_pkg;
  typedef enum logic [2:0] {
    OAD_SRC_IMM, OAD_SRC_DIR, OAD_SRC_IDX, OAD_DST_DIR, OAD_DST_IDX, OAD_DST_DIR_IMM
  } oad_mode_t;
  typedef enum logic [1:0] {OAD_R_A, OAD_R_X, OAD_R_STACK_POINTER, OAD_R_F} oad_reg_t;
endpackage
